// ### core/port_pin_function_mux.sv
// How it works
// - Per-bit TTL input buffer on two pins.
// - Per-bit open-drain output on two port 1 pins and all three port 0 pins.
// - Direction bit sets input or output.
// - Pull-up only when its option bit set.
// - Each pin outside port 2 picks port or alternate independently.
// - Clock pin gives divided or raw oscillation.
// - Correction pin gives 1 Hz clock.
// - Interrupt edge rising, falling or both.
// - Analog pins come up digital inputs.
// - Debug clock pin usable as port in one-line.
// - Timer pins feed count input, drive output.
`default_nettype none
`include "port_mux_map.svh"
module port_pin_function_mux
	import port_mux_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Pin pads: input level, output value, output enable
	input wire logic [`P0_W-1:0] p0_pad_i,
	output logic [`P0_W-1:0] p0_pad_o,
	output logic [`P0_W-1:0] p0_pad_oe_o,
	input wire logic [`P1_W-1:0] p1_pad_i,
	output logic [`P1_W-1:0] p1_pad_o,
	output logic [`P1_W-1:0] p1_pad_oe_o,
	output logic [`P1_W-1:0] p1_pullup_o,
	output logic [`P1_W-1:0] p1_ttl_sel_o,
	input wire logic [`P2_W-1:0] p2_pad_i,
	output logic [`P2_W-1:0] p2_pad_o,
	output logic [`P2_W-1:0] p2_pad_oe_o,
	output logic [`P2_W-1:0] p2_analog_en_o,
	input wire logic [`P3_W-1:0] p3_pad_i,
	output logic [`P3_W-1:0] p3_pad_o,
	output logic [`P3_W-1:0] p3_pad_oe_o,
	output logic [`P3_W-1:0] p3_pullup_o,
	input wire logic [`P4_W-1:0] p4_pad_i,
	output logic [`P4_W-1:0] p4_pad_o,
	output logic [`P4_W-1:0] p4_pad_oe_o,
	output logic [`P4_W-1:0] p4_pullup_o,
	// Port configuration
	input wire logic [`P0_W-1:0] port0_output_style_i,
	input wire logic [`P0_W-1:0] port0_direction_i,
	input wire logic [`P1_W-1:0] port1_direction_i,
	input wire logic [`P2_W-1:0] port2_direction_i,
	input wire logic [`P3_W-1:0] port3_direction_i,
	input wire logic [`P4_W-1:0] port4_direction_i,
	input wire logic [`P1_W-1:0] port1_pullup_enable_i,
	input wire logic [`P3_W-1:0] port3_pullup_enable_i,
	input wire logic [`P4_W-1:0] port4_pullup_enable_i,
	input wire logic [1:0] port1_input_buffer_select_i,
	input wire logic [1:0] port1_output_style_i,
	input wire logic [`P2_W-1:0] port2_analog_sel_i,
	// Output latches
	input wire logic [`P0_W-1:0] p0_latch_i,
	input wire logic [`P1_W-1:0] p1_latch_i,
	input wire logic [`P2_W-1:0] p2_latch_i,
	input wire logic [`P3_W-1:0] p3_latch_i,
	input wire logic [`P4_W-1:0] p4_latch_i,
	// Alternate-function select per pin
	input wire logic [`P0_W-1:0] p0_alt_sel_i,
	input wire logic [`P1_W-1:0] p1_alt_sel_i,
	input wire logic [`P3_W-1:0] p3_alt_sel_i,
	input wire logic [`P4_W-1:0] p4_alt_sel_i,
	// Peripheral drive per pin, used in alternate mode
	input wire logic [`P0_W-1:0] p0_alt_out_i,
	input wire logic [`P0_W-1:0] p0_alt_oe_i,
	input wire logic [`P1_W-1:0] p1_alt_out_i,
	input wire logic [`P1_W-1:0] p1_alt_oe_i,
	input wire logic [`P3_W-1:0] p3_alt_out_i,
	input wire logic [`P3_W-1:0] p3_alt_oe_i,
	// Real-time counter clocks
	input wire logic rtc_osc_32k_i,
	input wire logic rtc_div_clk_i,
	input wire logic rtc_1hz_i,
	input wire rtc_out_sel_e rtc_out_sel_i,
	input wire logic rtc_1hz_en_i,
	// Timers and debugger
	input wire logic timer1_out_i,
	input wire logic timer2_out_i,
	input wire logic timer4_out_i,
	input wire logic debug_two_line_i,
	input wire logic debug_data_out_i,
	input wire logic debug_data_oe_i,
	input wire logic debug_clk_out_i,
	// Interrupt edge selects
	input wire edge_sel_t ext_irq_in_4_edge_i,
	input wire edge_sel_t ext_irq_in_5_edge_i,
	// Synchronised pin levels and peripheral inputs
	output logic [`P0_W-1:0] p0_in_o,
	output logic [`P1_W-1:0] p1_in_o,
	output logic [`P2_W-1:0] p2_in_o,
	output logic [`P3_W-1:0] p3_in_o,
	output logic [`P4_W-1:0] p4_in_o,
	output logic timer1_count_in_o,
	output logic timer2_count_in_o,
	output logic timer3_count_in_o,
	output logic timer4_count_in_o,
	output logic debug_data_in_o,
	output logic ext_irq_in_4_o,
	output logic ext_irq_in_5_o
);
	import port_mux_pkg::*;

	logic [`P0_W-1:0] s0;
	logic [`P1_W-1:0] s1;
	logic [`P2_W-1:0] s2;
	logic [`P3_W-1:0] s3;
	logic [`P4_W-1:0] s4;
	logic [`P2_W-1:0] analog_reg;

	pin_sync #(.W(`P0_W)) u_s0 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(p0_pad_i),
		.sync_o(s0));
	pin_sync #(.W(`P1_W)) u_s1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(p1_pad_i),
		.sync_o(s1));
	pin_sync #(.W(`P2_W)) u_s2 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(p2_pad_i),
		.sync_o(s2));
	pin_sync #(.W(`P3_W)) u_s3 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(p3_pad_i),
		.sync_o(s3));
	pin_sync #(.W(`P4_W)) u_s4 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .async_i(p4_pad_i),
		.sync_o(s4));

	// Analog enable forced off through reset
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			analog_reg <= `ANALOG_SEL_RST;
		end else begin
			analog_reg <= port2_analog_sel_i;
		end
	end
	assign p2_analog_en_o = analog_reg;

	// Port 1 alternate drive, RTC and timer pins
	wire rtc_div_on = rtc_out_sel_i == RTC_OUT_DIV;
	wire rtc_raw_on = rtc_out_sel_i == RTC_OUT_RAW;
	wire rtc_pin_val = rtc_raw_on ? rtc_osc_32k_i : rtc_div_clk_i;
	logic [`P1_W-1:0] p1_per_out;
	logic [`P1_W-1:0] p1_per_oe;
	always_comb begin
		p1_per_out = p1_alt_out_i;
		p1_per_oe = p1_alt_oe_i;
		p1_per_out[`P1_RTC_BIT] = rtc_pin_val;
		p1_per_oe[`P1_RTC_BIT] = rtc_div_on | rtc_raw_on;
		p1_per_out[`P1_TMR1_BIT] = timer1_out_i;
		p1_per_oe[`P1_TMR1_BIT] = 1'b1;
		p1_per_out[`P1_TMR2_BIT] = timer2_out_i;
		p1_per_oe[`P1_TMR2_BIT] = 1'b1;
	end

	// Port 3 correction clock or timer 3 output
	wire [`P3_W-1:0] p3_per_out = rtc_1hz_en_i ? rtc_1hz_i : p3_alt_out_i;
	wire [`P3_W-1:0] p3_per_oe = rtc_1hz_en_i ? 1'b1 : p3_alt_oe_i;

	// Port 4 debugger and timer 4
	logic [`P4_W-1:0] p4_sel;
	logic [`P4_W-1:0] p4_per_out;
	logic [`P4_W-1:0] p4_per_oe;
	always_comb begin
		p4_sel = p4_alt_sel_i;
		p4_sel[`P4_DBG_CLK_BIT] = p4_alt_sel_i[`P4_DBG_CLK_BIT] | debug_two_line_i;
		p4_per_out = '0;
		p4_per_oe = '0;
		p4_per_out[`P4_DBG_DATA_BIT] = debug_data_out_i;
		p4_per_oe[`P4_DBG_DATA_BIT] = debug_data_oe_i;
		p4_per_out[`P4_DBG_CLK_BIT] = debug_clk_out_i;
		p4_per_oe[`P4_DBG_CLK_BIT] = 1'b1;
		p4_per_out[`P4_TMR4_BIT] = timer4_out_i;
		p4_per_oe[`P4_TMR4_BIT] = 1'b1;
	end

	// Open-drain style per bit: output enable only while driving low
	logic [`P1_W-1:0] p1_od;
	always_comb begin
		p1_od = '0;
		p1_od[`P1_SCK0_BIT] = port1_output_style_i[0];
		p1_od[`P1_TX0_BIT] = port1_output_style_i[1];
	end
	always_comb begin
		p1_ttl_sel_o = '0;
		p1_ttl_sel_o[`P1_SCK0_BIT] = port1_input_buffer_select_i[0];
		p1_ttl_sel_o[`P1_RX0_BIT] = port1_input_buffer_select_i[1];
	end

	// Per-pin selection
	genvar i;
	generate
		for (i = 0; i < `P1_W; i++) begin : g_p1
			wire alt = p1_alt_sel_i[i];
			wire v = alt ? p1_per_out[i] : p1_latch_i[i];
			wire en = alt ? p1_per_oe[i] : ~port1_direction_i[i];
			assign p1_pad_o[i] = v;
			assign p1_pad_oe_o[i] = en & ~(p1_od[i] & v);
			assign p1_pullup_o[i] = ~alt & port1_direction_i[i] & port1_pullup_enable_i[i];
		end
		for (i = 0; i < `P0_W; i++) begin : g_p0
			wire v = p0_alt_sel_i[i] ? p0_alt_out_i[i] : p0_latch_i[i];
			wire en = p0_alt_sel_i[i] ? p0_alt_oe_i[i] : ~port0_direction_i[i];
			assign p0_pad_o[i] = v;
			assign p0_pad_oe_o[i] = en & ~(port0_output_style_i[i] & v);
		end
		for (i = 0; i < `P2_W; i++) begin : g_p2
			assign p2_pad_o[i] = p2_latch_i[i];
			assign p2_pad_oe_o[i] = ~analog_reg[i] & ~port2_direction_i[i];
		end
		for (i = 0; i < `P3_W; i++) begin : g_p3
			wire alt = p3_alt_sel_i[i] | rtc_1hz_en_i;
			assign p3_pad_o[i] = alt ? p3_per_out[i] : p3_latch_i[i];
			assign p3_pad_oe_o[i] = alt ? p3_per_oe[i] : ~port3_direction_i[i];
			assign p3_pullup_o[i] = ~alt & port3_direction_i[i] & port3_pullup_enable_i[i];
		end
		for (i = 0; i < `P4_W; i++) begin : g_p4
			assign p4_pad_o[i] = p4_sel[i] ? p4_per_out[i] : p4_latch_i[i];
			assign p4_pad_oe_o[i] = p4_sel[i] ? p4_per_oe[i] : ~port4_direction_i[i];
			assign p4_pullup_o[i] = ~p4_sel[i] & port4_direction_i[i] & port4_pullup_enable_i[i];
		end
	endgenerate

	// Digital input reads zero while analog is selected
	assign p0_in_o = s0;
	assign p1_in_o = s1;
	assign p2_in_o = s2 & ~analog_reg;
	assign p3_in_o = s3;
	assign p4_in_o = s4;

	// Timer count inputs, only in alternate mode
	assign timer1_count_in_o = s1[`P1_TMR1_BIT] & p1_alt_sel_i[`P1_TMR1_BIT];
	assign timer2_count_in_o = s1[`P1_TMR2_BIT] & p1_alt_sel_i[`P1_TMR2_BIT];
	assign timer3_count_in_o = s3[0] & p3_alt_sel_i[0];
	assign timer4_count_in_o = s4[`P4_TMR4_BIT] & p4_sel[`P4_TMR4_BIT];
	assign debug_data_in_o = s4[`P4_DBG_DATA_BIT];

	edge_detect u_irq4 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .edge_sel_i(ext_irq_in_4_edge_i),
		.level_i(s3[0]), .req_o(ext_irq_in_4_o));
	edge_detect u_irq5 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .edge_sel_i(ext_irq_in_5_edge_i),
		.level_i(s1[`P1_TMR1_BIT]), .req_o(ext_irq_in_5_o));
endmodule : port_pin_function_mux
`default_nettype wire

// ### core/port_mux_map.svh
`ifndef PORT_MUX_MAP_SVH
`define PORT_MUX_MAP_SVH

// Pin counts per port
`define P0_W 3
`define P1_W 8
`define P2_W 8
`define P3_W 1
`define P4_W 4

// Port 1 bit positions
`define P1_SCK0_BIT 0
`define P1_RX0_BIT 1
`define P1_TX0_BIT 2
`define P1_TX3_BIT 3
`define P1_RX3_BIT 4
`define P1_RTC_BIT 5
`define P1_TMR1_BIT 6
`define P1_TMR2_BIT 7

// Port 4 bit positions
`define P4_DBG_DATA_BIT 0
`define P4_DBG_CLK_BIT 1
`define P4_TMR4_BIT 2

// Reset values: all pins input, port 2 analog select off
`define DIR_RST_P0 3'h7
`define DIR_RST_P1 8'hFF
`define DIR_RST_P2 8'hFF
`define DIR_RST_P3 1'h1
`define DIR_RST_P4 4'hF
`define ANALOG_SEL_RST 8'h00

// Edge select codes
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

`endif

// ### core/port_mux_pkg.sv
`default_nettype none
package port_mux_pkg;
	typedef logic [1:0] edge_sel_t;
	typedef enum logic [1:0] {
		RTC_OUT_NONE = 2'h0,
		RTC_OUT_DIV = 2'h1,
		RTC_OUT_RAW = 2'h2
	} rtc_out_sel_e;
endpackage : port_mux_pkg
`default_nettype wire

// ### core/pin_sync.sv
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end
	assign sync_o = sync_reg;
endmodule : pin_sync
`default_nettype wire

// ### core/edge_detect.sv
`default_nettype none
`include "port_mux_map.svh"
module edge_detect (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [1:0] edge_sel_i,
	input wire logic level_i,
	output logic req_o
);
	logic prev_reg;
	logic req_reg;
	wire rise = level_i & ~prev_reg;
	wire fall = ~level_i & prev_reg;
	wire hit = (edge_sel_i == `EDGE_RISE && rise) || (edge_sel_i == `EDGE_FALL && fall)
		|| (edge_sel_i == `EDGE_BOTH && (rise || fall));
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			prev_reg <= 1'b0;
			req_reg <= 1'b0;
		end else begin
			prev_reg <= level_i;
			req_reg <= hit;
		end
	end
	assign req_o = req_reg;
endmodule : edge_detect
`default_nettype wire

// ### verification/port_pin_function_mux_chk.sv
`default_nettype none
`include "port_mux_map.svh"
module port_pin_function_mux_chk
	import port_mux_pkg::*;
(
	// Clock and reset
	input wire logic clk_i, sys_rst_i,
	// Watched ports
	input wire logic [7:0] p1_pad_i, p1_pad_o, p1_pad_oe_o, p1_pullup_o, p1_ttl_sel_o,
	input wire logic [7:0] p2_analog_en_o, port1_direction_i, port1_pullup_enable_i,
	input wire logic [7:0] p1_latch_i, p1_alt_sel_i,
	input wire logic [0:0] p3_pad_o, p3_pad_oe_o,
	input wire logic [3:0] p4_pad_o, p4_pad_oe_o, port4_direction_i, p4_alt_sel_i,
	input wire logic [1:0] port1_input_buffer_select_i, port1_output_style_i,
	input wire logic rtc_osc_32k_i, rtc_div_clk_i, rtc_1hz_i, rtc_1hz_en_i,
	input wire logic timer1_out_i, debug_two_line_i, debug_clk_out_i, ext_irq_in_5_o,
	input wire rtc_out_sel_e rtc_out_sel_i,
	input wire edge_sel_t ext_irq_in_5_edge_i
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	a_dir_drive: assert property (!p1_alt_sel_i[3] |-> p1_pad_oe_o[3] == !port1_direction_i[3])
		else $error("p1 pin 3 enable does not follow direction");
	a_pullup_gate: assert property (p1_pullup_o[3] ==
		(!p1_alt_sel_i[3] && port1_direction_i[3] && port1_pullup_enable_i[3]))
		else $error("p1 pin 3 pull-up wrong");
	a_ttl_select: assert property (p1_ttl_sel_o[1:0] == port1_input_buffer_select_i)
		else $error("ttl select wrong");
	a_open_drain: assert property ((!p1_alt_sel_i[0] && !port1_direction_i[0] &&
		port1_output_style_i[0]) |-> p1_pad_oe_o[0] == !p1_latch_i[0])
		else $error("open drain enable wrong");
	a_rtc_clock: assert property ((p1_alt_sel_i[5] && rtc_out_sel_i != RTC_OUT_NONE) |->
		p1_pad_o[5] == (rtc_out_sel_i == RTC_OUT_DIV ? rtc_div_clk_i : rtc_osc_32k_i))
		else $error("rtc clock pin wrong");
	a_corr_clock: assert property (rtc_1hz_en_i |-> p3_pad_o[0] == rtc_1hz_i && p3_pad_oe_o[0])
		else $error("correction clock pin wrong");
	a_debug_clock: assert property (debug_two_line_i |->
		p4_pad_o[1] == debug_clk_out_i && p4_pad_oe_o[1])
		else $error("debug clock pin wrong");
	a_debug_port: assert property ((!debug_two_line_i && !p4_alt_sel_i[1]) |->
		p4_pad_oe_o[1] == !port4_direction_i[1])
		else $error("debug clock pin not a port");
	a_timer_out: assert property (p1_alt_sel_i[6] |-> p1_pad_o[6] == timer1_out_i && p1_pad_oe_o[6])
		else $error("timer output pin wrong");
	a_analog_reset: assert property ($fell(sys_rst_i) |-> p2_analog_en_o == 8'h00)
		else $error("analog select not clear after reset");
	a_irq_rise: assert property (($rose(p1_pad_i[6]) && ext_irq_in_5_edge_i == `EDGE_RISE) |->
		##[1:4] ext_irq_in_5_o)
		else $error("rising edge request missing");
	a_irq_none: assert property ((ext_irq_in_5_edge_i == `EDGE_NONE) [*4] |-> !ext_irq_in_5_o)
		else $error("request with no edge selected");
endmodule : port_pin_function_mux_chk
bind port_pin_function_mux port_pin_function_mux_chk chk_u (.*);
`default_nettype wire

// ### verification/tb_port_pin_function_mux.sv
`default_nettype none
module tb_port_pin_function_mux;
	import port_mux_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, sys_rst_i, rtc_osc_32k_i, rtc_div_clk_i, rtc_1hz_i, rtc_1hz_en_i;
	logic timer1_out_i, timer2_out_i, timer4_out_i, debug_two_line_i, debug_data_out_i;
	logic debug_data_oe_i, debug_clk_out_i, timer1_count_in_o, timer2_count_in_o;
	logic timer3_count_in_o, timer4_count_in_o, debug_data_in_o, ext_irq_in_4_o, ext_irq_in_5_o;
	logic [0:0] p3_pad_i, p3_pad_o, p3_pad_oe_o, p3_pullup_o, port3_direction_i, p3_in_o;
	logic [0:0] port3_pullup_enable_i, p3_latch_i, p3_alt_sel_i, p3_alt_out_i, p3_alt_oe_i;
	logic [2:0] p0_pad_i, p0_pad_o, p0_pad_oe_o, port0_output_style_i, port0_direction_i;
	logic [2:0] p0_latch_i, p0_alt_sel_i, p0_alt_out_i, p0_alt_oe_i, p0_in_o;
	logic [7:0] p1_pad_i, p1_pad_o, p1_pad_oe_o, p1_pullup_o, p1_ttl_sel_o, p2_pad_i, p2_pad_o;
	logic [7:0] p2_pad_oe_o, p2_analog_en_o, port1_direction_i, port2_direction_i, p1_in_o;
	logic [7:0] port1_pullup_enable_i, port2_analog_sel_i, p1_latch_i, p2_latch_i, p2_in_o;
	logic [7:0] p1_alt_sel_i, p1_alt_out_i, p1_alt_oe_i, oe, v;
	logic [3:0] p4s;
	logic [3:0] p4_pad_i, p4_pad_o, p4_pad_oe_o, p4_pullup_o, port4_direction_i, p4_in_o;
	logic [3:0] port4_pullup_enable_i, p4_latch_i, p4_alt_sel_i;
	logic [1:0] port1_input_buffer_select_i, port1_output_style_i;
	logic [159:0] r;
	rtc_out_sel_e rtc_out_sel_i;
	edge_sel_t ext_irq_in_4_edge_i, ext_irq_in_5_edge_i;
	int err_count = 0;
	int num_checks = 0;
	int n4, n5;
	port_pin_function_mux dut_u (.*);
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	// All inputs random, interrupt edges off
	task automatic rnd();
		r = {$urandom, $urandom, $urandom, $urandom, $urandom};
		{port0_output_style_i, port0_direction_i, port1_direction_i, port2_direction_i,
			port3_direction_i, port4_direction_i, port1_pullup_enable_i, port3_pullup_enable_i,
			port4_pullup_enable_i, port1_input_buffer_select_i, port1_output_style_i,
			port2_analog_sel_i, p0_latch_i, p1_latch_i, p2_latch_i, p3_latch_i, p4_latch_i,
			p0_alt_sel_i, p1_alt_sel_i, p3_alt_sel_i, p4_alt_sel_i, p0_alt_out_i, p0_alt_oe_i,
			p1_alt_out_i, p1_alt_oe_i, p3_alt_out_i, p3_alt_oe_i, p0_pad_i, p1_pad_i, p2_pad_i,
			p3_pad_i, p4_pad_i, timer1_out_i, timer2_out_i, timer4_out_i, debug_two_line_i,
			debug_data_out_i, debug_data_oe_i, debug_clk_out_i, rtc_osc_32k_i, rtc_div_clk_i,
			rtc_1hz_i, rtc_1hz_en_i} <= r[150:0];
		rtc_out_sel_i <= rtc_out_sel_e'($urandom_range(2));
		ext_irq_in_4_edge_i <= 2'h0;
		ext_irq_in_5_edge_i <= 2'h0;
	endtask : rnd
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		#40000;
		err_count++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'hAC15FDE7));
		sys_rst_i <= 1'b1;
		rnd();
		port2_analog_sel_i <= 8'hFF;
		p1_pad_i <= 8'h00;
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_i);
		chk("analog_en", 8'h00, p2_analog_en_o);
		$display("test reset done");
		repeat (300) begin
			@(posedge clk_i);
			rnd();
			repeat (3) @(posedge clk_i);
			#1;
			v = (p1_alt_sel_i & p1_alt_out_i) | (~p1_alt_sel_i & p1_latch_i);
			oe = ((p1_alt_sel_i & p1_alt_oe_i) | (~p1_alt_sel_i & ~port1_direction_i)) & 8'h1F;
			oe[0] = oe[0] & ~(port1_output_style_i[0] & v[0]);
			oe[2] = oe[2] & ~(port1_output_style_i[1] & v[2]);
			chk("p1_oe", oe, p1_pad_oe_o & 8'h1F);
			chk("p1_out", v & oe, p1_pad_o & oe);
			chk("p1_pullup", ~p1_alt_sel_i & port1_direction_i & port1_pullup_enable_i & 8'h1F,
				p1_pullup_o & 8'h1F);
			chk("p1_ttl", {6'h0, port1_input_buffer_select_i}, p1_ttl_sel_o & 8'h03);
			chk("p1_in", p1_pad_i, p1_in_o);
			chk("p2_in", p2_pad_i & ~port2_analog_sel_i, p2_in_o);
			v = {5'h0, (p0_alt_sel_i & p0_alt_out_i) | (~p0_alt_sel_i & p0_latch_i)};
			oe = {5'h0, ((p0_alt_sel_i & p0_alt_oe_i) | (~p0_alt_sel_i & ~port0_direction_i))
				& ~(port0_output_style_i & v[2:0])};
			chk("p0_oe", oe, {5'h0, p0_pad_oe_o});
			chk("p0_out", v, {5'h0, p0_pad_o});
			chk("p2_oe", ~port2_analog_sel_i & ~port2_direction_i, p2_pad_oe_o);
			chk("p2_out", p2_latch_i, p2_pad_o);
			p4s = p4_alt_sel_i | {2'h0, debug_two_line_i, 1'b0};
			chk("p4_pullup", {4'h0, ~p4s & port4_direction_i & port4_pullup_enable_i},
				{4'h0, p4_pullup_o});
			chk("p3_pullup", {7'h0, ~(p3_alt_sel_i[0] | rtc_1hz_en_i) & port3_direction_i[0]
				& port3_pullup_enable_i[0]}, {7'h0, p3_pullup_o});
			chk("tmr_cnt", {5'h0, p4_pad_i[2] & p4s[2], p3_pad_i[0] & p3_alt_sel_i[0],
				p1_pad_i[7] & p1_alt_sel_i[7]}, {5'h0, timer4_count_in_o, timer3_count_in_o,
				timer2_count_in_o});
			chk("pin_in", {p4_pad_i, p3_pad_i, p0_pad_i}, {p4_in_o, p3_in_o, p0_in_o});
			chk("dbg_in", {7'h0, p4_pad_i[0]}, {7'h0, debug_data_in_o});
		end
		$display("test random done");
		// Clock, timer and debug pins over divided and raw clock select, one- and two-line debug
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			p1_alt_sel_i <= 8'hE0;
			port0_output_style_i <= 3'h0;
			rtc_out_sel_i <= i[0] ? RTC_OUT_RAW : RTC_OUT_DIV;
			rtc_osc_32k_i <= i[1];
			rtc_div_clk_i <= !i[1];
			rtc_1hz_en_i <= 1'b1;
			rtc_1hz_i <= i[0];
			debug_two_line_i <= i[1];
			debug_clk_out_i <= i[0];
			p4_alt_sel_i <= 4'h0;
			port4_direction_i <= 4'h0;
			p4_latch_i <= {4{!i[0]}};
			timer1_out_i <= i[1];
			p1_pad_i[6] <= i[0];
			repeat (3) @(posedge clk_i);
			#1;
			chk("rtc_pin", i[0] ? i[1] : !i[1], p1_pad_o[5]);
			chk("corr_pin", i[0], p3_pad_o[0]);
			chk("dbg_clk", i[1] ? i[0] : !i[0], p4_pad_o[1]);
			chk("dbg_oe", 8'h01, p4_pad_oe_o[1]);
			chk("tmr_out", i[1], p1_pad_o[6]);
			chk("tmr_in", i[0], timer1_count_in_o);
		end
		$display("test alternate pins done");
		// Edge codes none, rise, fall, both
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			ext_irq_in_4_edge_i <= edge_sel_t'(i);
			ext_irq_in_5_edge_i <= edge_sel_t'(i);
			p3_alt_sel_i <= 1'b1;
			p1_pad_i[6] <= 1'b0;
			p3_pad_i <= 1'b0;
			repeat (6) @(posedge clk_i);
			n4 = 0;
			n5 = 0;
			p1_pad_i[6] <= 1'b1;
			p3_pad_i <= 1'b1;
			repeat (16) begin
				@(negedge clk_i);
				n4 += ext_irq_in_4_o;
				n5 += ext_irq_in_5_o;
				if (n4 + n5 == 99) p3_pad_i <= 1'b0;
			end
			@(posedge clk_i);
			p1_pad_i[6] <= 1'b0;
			p3_pad_i <= 1'b0;
			repeat (16) begin
				@(negedge clk_i);
				n4 += ext_irq_in_4_o;
				n5 += ext_irq_in_5_o;
			end
			chk("irq5_count", (i == 3) ? 8'h02 : 8'(i != 0), 8'(n5));
			chk("irq4_count", (i == 3) ? 8'h02 : 8'(i != 0), 8'(n4));
		end
		$display("test interrupt edges done");
		print_verdict();
	end
endmodule : tb_port_pin_function_mux
`default_nettype wire
